// ### empcrs_defines.svh
// empcrs_defines.svh: constants of the clock and reset coordinator.
// assumes: included by its bare name wherever a constant is needed.
`ifndef EMPCRS_DEFINES_SVH
`define EMPCRS_DEFINES_SVH

// ----------------------------------------------------------------------
// system clock and dividers
// ----------------------------------------------------------------------
`define EMPCRS_CLK_KHZ 20000
`define EMPCRS_NEG_KHZ_DEF 5000
`define EMPCRS_HELP_KHZ_DEF 10000
`define EMPCRS_DIV_W 16
`define EMPCRS_MS_W 16

// ----------------------------------------------------------------------
// reset release and rate check
// ----------------------------------------------------------------------
`define EMPCRS_RST_HOLD 4
`define EMPCRS_HOLD_W 4
`define EMPCRS_WIN 16
`define EMPCRS_WIN_W 6
`define EMPCRS_DOMS_FIFO 2'h3
`define EMPCRS_DOMS_LL 2'h2

// ----------------------------------------------------------------------
// synchroniser bit positions
// ----------------------------------------------------------------------
`define EMPCRS_SYN_W 9
`define EMPCRS_SYN_FIFO 3
`define EMPCRS_SYN_RST0 4

`endif

// ### empcrs_pkg.sv
// empcrs_pkg.sv: types of the clock and reset coordinator.
// assumes: compiled before any module that imports it.
package empcrs_pkg;

   // ----------------------------------------------------------------------
   // clock domains handled by the coordinator
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      EMPCRS_DOM_TX = 3'h0,
      EMPCRS_DOM_RXS = 3'h1,
      EMPCRS_DOM_RXC = 3'h2,
      EMPCRS_DOM_NEG = 3'h3,
      EMPCRS_DOM_HLP = 3'h4
   } empcrs_dom_t;

   localparam int EMPCRS_NDOM = 5;

endpackage : empcrs_pkg

// ### empcrs_sync.sv
// empcrs_sync.sv: two-flop synchronisers with rising-edge detection.
// assumes: inputs are asynchronous to clk; outputs are clk-domain levels.
`timescale 1ns/1ns
`default_nettype none

module empcrs_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q,
   output logic [W-1:0] rise
);

   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;

   // ----------------------------------------------------------------------
   // first stage is read by the second stage only
   // ----------------------------------------------------------------------
   // no reset on the stages: clearing them would show every pin low for
   // two cycles after reset, a false request release and a false variant
   always_ff @(posedge clk) begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
   end

   assign q = s2_r;
   // edges are not reported while reset is held
   assign rise = s2_r & ~s3_r & ~{W{srst}};

endmodule : empcrs_sync

`default_nettype wire

// ### empcrs_top.sv
// empcrs_top.sv: clock-domain and reset coordinator of the mac/pcs core.
// assumes: serdes and core clocks arrive as pins sampled by CLK, which is
// much faster; every domain is carried as a one-cycle tick of CLK.
`timescale 1ns/1ns
`default_nettype none
`include "empcrs_defines.svh"

// Behaviour
// R01: integrator keeps tx serdes clock within tolerance
// R02: fifo variant streams tx on tx clock
// R03: rx core clock not slower than tx
// R04: tie tx clock to rx core preferably
// R05: user answers tx ready in same cycle
// R06: low-latency rx stream follows recovered clock
// R07: low-latency has two domains, fifo three
// R08: negotiation logic only with kr/cr option
// R09: training ticks on serdes clocks
// R10: negotiation clock rate is timer reference
// R11: helper clock free-running, rate configured
// R12: separate resets per path and domain
// R13: resets coordinated, any order works
// R14: user holds reset until clock stable
// R15: mode input changes only under reset
// R16: reset needs own clock edge while asserted
// R17: async mode tolerates ppm offset between paths
// R18: every crossing passes synchronisers
module empcrs_top import empcrs_pkg::*; #(
   parameter int NEG_KHZ = `EMPCRS_NEG_KHZ_DEF,
   parameter int HELP_KHZ = `EMPCRS_HELP_KHZ_DEF,
   parameter bit AN_PRESENT = 1'h1,
   parameter int RST_HOLD = `EMPCRS_RST_HOLD
) (
   input wire logic CLK,
   input wire logic SRST,
   input wire logic TX_SERDES_CLK_IN,
   input wire logic RX_SERDES_CLK_IN,
   input wire logic RX_CORE_CLK_IN,
   input wire logic FIFO_MODE_IN,
   input wire logic TX_RESET_IN,
   input wire logic RX_RESET_IN,
   input wire logic RX_CORE_RESET_IN,
   input wire logic NEG_RESET_IN,
   input wire logic HELPER_RESET_IN,
   output logic TX_CLK_TICK,
   output logic RX_CLK_TICK,
   output logic RX_STREAM_TICK,
   output logic TRAIN_TX_TICK,
   output logic TRAIN_RX_TICK,
   output logic NEG_TICK,
   output logic NEG_MS_TICK,
   output logic HELPER_TICK,
   output logic TX_RST,
   output logic RX_SERDES_RST,
   output logic RX_CORE_RST,
   output logic NEG_RST,
   output logic HELPER_RST,
   output logic FIFO_MODE,
   output logic [1:0] DOMAIN_COUNT,
   output logic RX_CORE_SLOW
);

   localparam int DW = `EMPCRS_DIV_W;
   localparam int MW = `EMPCRS_MS_W;
   localparam int HW = `EMPCRS_HOLD_W;
   localparam int WW = `EMPCRS_WIN_W;
   localparam int NEG_DIV = (`EMPCRS_CLK_KHZ / NEG_KHZ < 1) ? 1 :
                            `EMPCRS_CLK_KHZ / NEG_KHZ;
   localparam int HELP_DIV = (`EMPCRS_CLK_KHZ / HELP_KHZ < 1) ? 1 :
                             `EMPCRS_CLK_KHZ / HELP_KHZ;
   localparam logic [DW-1:0] NEG_LAST = DW'(NEG_DIV - 1);
   localparam logic [DW-1:0] HELP_LAST = DW'(HELP_DIV - 1);
   localparam logic [MW-1:0] MS_LAST = MW'(NEG_KHZ - 1);
   localparam logic [HW-1:0] HOLD_LAST = HW'(RST_HOLD - 1);
   localparam logic [WW-1:0] WIN_LAST = WW'(`EMPCRS_WIN - 1);
   localparam logic [WW-1:0] WIN_MIN = WW'(`EMPCRS_WIN - 1);
   localparam int ITX = int'(EMPCRS_DOM_TX);
   localparam int IRS = int'(EMPCRS_DOM_RXS);
   localparam int IRC = int'(EMPCRS_DOM_RXC);
   localparam int INE = int'(EMPCRS_DOM_NEG);
   localparam int IHL = int'(EMPCRS_DOM_HLP);

   logic [`EMPCRS_SYN_W-1:0] syn_d;
   logic [`EMPCRS_SYN_W-1:0] syn_q;
   logic [`EMPCRS_SYN_W-1:0] syn_rise;
   logic [EMPCRS_NDOM-1:0] req;
   logic [EMPCRS_NDOM-1:0] req_eff;
   logic [EMPCRS_NDOM-1:0] dom_tick;
   logic [EMPCRS_NDOM-1:0] rst_r;
   logic [HW-1:0] hold_r [EMPCRS_NDOM];
   logic [DW-1:0] neg_cnt_r;
   logic [DW-1:0] help_cnt_r;
   logic [MW-1:0] ms_cnt_r;
   logic neg_tick_r;
   logic help_tick_r;
   logic fifo_mode_r;
   logic [WW-1:0] win_r;
   logic [WW-1:0] core_cnt_r;
   logic slow_set;

   // ----------------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------------
   assign syn_d = {HELPER_RESET_IN, NEG_RESET_IN, RX_CORE_RESET_IN,
                   RX_RESET_IN, TX_RESET_IN, FIFO_MODE_IN,
                   RX_CORE_CLK_IN, RX_SERDES_CLK_IN, TX_SERDES_CLK_IN};

   empcrs_sync #(.W(`EMPCRS_SYN_W)) u_sync ( // [R18]
      .clk(CLK),
      .srst(SRST),
      .d(syn_d),
      .q(syn_q),
      .rise(syn_rise)
   );

   assign req = syn_q[`EMPCRS_SYN_RST0 +: EMPCRS_NDOM]; // [R12]
   assign dom_tick = {help_tick_r, neg_tick_r, syn_rise[IRC],
                      syn_rise[IRS], syn_rise[ITX]};

   // core waits for recovered side; low-latency keeps core domain parked
   assign req_eff[ITX] = req[ITX];
   assign req_eff[IRS] = req[IRS];
   assign req_eff[IRC] = req[IRC] | ~fifo_mode_r | rst_r[IRS]; // [R13] [R07]
   assign req_eff[INE] = req[INE] | ~AN_PRESENT; // [R08]
   assign req_eff[IHL] = req[IHL];

   // ----------------------------------------------------------------------
   // negotiation and helper dividers
   // ----------------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (SRST || neg_cnt_r == NEG_LAST) begin
         neg_cnt_r <= '0;
      end else begin
         neg_cnt_r <= neg_cnt_r + DW'(1);
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         neg_tick_r <= 1'h0;
      end else begin
         neg_tick_r <= (neg_cnt_r == NEG_LAST) && AN_PRESENT; // [R10]
      end
   end

   // millisecond reference counts negotiation ticks at the configured rate
   always_ff @(posedge CLK) begin
      if (SRST || rst_r[INE]) begin
         ms_cnt_r <= '0;
      end else if (neg_tick_r) begin
         ms_cnt_r <= (ms_cnt_r == MS_LAST) ? '0 : ms_cnt_r + MW'(1); // [R10]
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST || help_cnt_r == HELP_LAST) begin
         help_cnt_r <= '0;
      end else begin
         help_cnt_r <= help_cnt_r + DW'(1);
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         help_tick_r <= 1'h0;
      end else begin
         help_tick_r <= (help_cnt_r == HELP_LAST); // [R11]
      end
   end

   // ----------------------------------------------------------------------
   // per-domain reset release
   // ----------------------------------------------------------------------
   // release waits for RST_HOLD ticks of its own domain, so a stopped clock keeps
   // its domain in reset however long the request has gone
   genvar gi;
   generate
      for (gi = 0; gi < EMPCRS_NDOM; gi++) begin : g_dom
         always_ff @(posedge CLK) begin
            if (SRST || req_eff[gi]) begin
               rst_r[gi] <= 1'h1;
               hold_r[gi] <= '0;
            end else if (rst_r[gi] && dom_tick[gi]) begin
               if (hold_r[gi] == HOLD_LAST) begin
                  rst_r[gi] <= 1'h0; // [R16] [R13]
               end
               hold_r[gi] <= hold_r[gi] + HW'(1);
            end
         end

         property p_release_on_tick;
            @(posedge CLK) disable iff (SRST)
            $fell(rst_r[gi]) |-> $past(dom_tick[gi]) && !$past(req_eff[gi]);
         endproperty
         a_release_on_tick: assert property (p_release_on_tick) // [R16]
            else $error("domain left reset without its own tick");

         property p_req_holds;
            @(posedge CLK) disable iff (SRST)
            req_eff[gi] |=> rst_r[gi] && hold_r[gi] == '0;
         endproperty
         a_req_holds: assert property (p_req_holds) // [R12]
            else $error("domain not held in reset by its request");
      end
   endgenerate

   // ----------------------------------------------------------------------
   // variant selection, taken only while both paths are in reset
   // ----------------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (SRST) begin
         fifo_mode_r <= 1'h1;
      end else if (rst_r[ITX] && rst_r[IRS]) begin
         fifo_mode_r <= syn_q[`EMPCRS_SYN_FIFO]; // [R15]
      end
   end

   property p_mode_stable;
      @(posedge CLK) disable iff (SRST)
      !(rst_r[ITX] && rst_r[IRS]) |=> $stable(fifo_mode_r);
   endproperty
   a_mode_stable: assert property (p_mode_stable) // [R15]
      else $error("variant changed outside reset");

   // ----------------------------------------------------------------------
   // rx core rate check over a window of tx ticks
   // ----------------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (SRST || rst_r[IRC] || rst_r[ITX]) begin
         win_r <= '0;
         core_cnt_r <= '0;
      end else if (syn_rise[ITX] && win_r == WIN_LAST) begin
         win_r <= '0;
         core_cnt_r <= syn_rise[IRC] ? WW'(1) : '0;
      end else begin
         win_r <= win_r + WW'(syn_rise[ITX]);
         core_cnt_r <= core_cnt_r + WW'(syn_rise[IRC]);
      end
   end

   // one tick of slack absorbs phase between the two sampled clocks
   assign slow_set = fifo_mode_r && !rst_r[IRC] && !rst_r[ITX] &&
                     syn_rise[ITX] && win_r == WIN_LAST &&
                     core_cnt_r < WIN_MIN; // [R03]

   always_ff @(posedge CLK) begin
      if (SRST) begin
         RX_CORE_SLOW <= 1'h0;
      end else if (slow_set) begin
         RX_CORE_SLOW <= 1'h1;
      end else if (rst_r[IRC]) begin
         RX_CORE_SLOW <= 1'h0;
      end
   end

   property p_slow_sticky;
      @(posedge CLK) disable iff (SRST)
      RX_CORE_SLOW && !rst_r[IRC] |=> RX_CORE_SLOW;
   endproperty
   a_slow_sticky: assert property (p_slow_sticky) // [R03]
      else $error("core rate flag dropped outside reset");

   // ----------------------------------------------------------------------
   // registered outputs
   // ----------------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (SRST) begin
         TX_CLK_TICK <= 1'h0;
         RX_CLK_TICK <= 1'h0;
         RX_STREAM_TICK <= 1'h0;
         TRAIN_TX_TICK <= 1'h0;
         TRAIN_RX_TICK <= 1'h0;
         NEG_TICK <= 1'h0;
         NEG_MS_TICK <= 1'h0;
         HELPER_TICK <= 1'h0;
      end else begin
         TX_CLK_TICK <= syn_rise[ITX]; // [R02] [R17]
         RX_CLK_TICK <= syn_rise[IRS]; // [R17]
         RX_STREAM_TICK <= fifo_mode_r ? syn_rise[IRC] :
                                         syn_rise[IRS]; // [R06]
         TRAIN_TX_TICK <= AN_PRESENT && syn_rise[ITX] && !rst_r[INE]; // [R09]
         TRAIN_RX_TICK <= AN_PRESENT && syn_rise[IRS] && !rst_r[INE]; // [R09]
         NEG_TICK <= neg_tick_r;
         NEG_MS_TICK <= neg_tick_r && ms_cnt_r == MS_LAST && !rst_r[INE];
         HELPER_TICK <= help_tick_r; // [R11]
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         FIFO_MODE <= 1'h1;
         DOMAIN_COUNT <= `EMPCRS_DOMS_FIFO;
      end else begin
         FIFO_MODE <= fifo_mode_r;
         DOMAIN_COUNT <= fifo_mode_r ? `EMPCRS_DOMS_FIFO :
                                       `EMPCRS_DOMS_LL; // [R07]
      end
   end

   assign TX_RST = rst_r[ITX];
   assign RX_SERDES_RST = rst_r[IRS];
   assign RX_CORE_RST = rst_r[IRC];
   assign NEG_RST = rst_r[INE];
   assign HELPER_RST = rst_r[IHL];

   property p_tx_tick;
      @(posedge CLK) disable iff (SRST)
      syn_rise[ITX] |=> TX_CLK_TICK;
   endproperty
   a_tx_tick: assert property (p_tx_tick) // [R02]
      else $error("tx tick lost");

   property p_stream_fifo;
      @(posedge CLK) disable iff (SRST)
      fifo_mode_r && syn_rise[IRC] |=> RX_STREAM_TICK;
   endproperty
   a_stream_fifo: assert property (p_stream_fifo) // [R02]
      else $error("rx stream not on core clock");

   property p_stream_ll;
      @(posedge CLK) disable iff (SRST)
      !fifo_mode_r |=> RX_STREAM_TICK == $past(syn_rise[IRS]);
   endproperty
   a_stream_ll: assert property (p_stream_ll) // [R06]
      else $error("rx stream not on recovered clock");

   property p_core_parked;
      @(posedge CLK) disable iff (SRST)
      !fifo_mode_r |=> rst_r[IRC] && DOMAIN_COUNT == `EMPCRS_DOMS_LL;
   endproperty
   a_core_parked: assert property (p_core_parked) // [R07]
      else $error("low-latency variant left core domain running");

   property p_core_after_serdes;
      @(posedge CLK) disable iff (SRST)
      rst_r[IRS] |=> rst_r[IRC];
   endproperty
   a_core_after_serdes: assert property (p_core_after_serdes) // [R13]
      else $error("core domain released before recovered domain");

   property p_neg_absent;
      @(posedge CLK) disable iff (SRST)
      !AN_PRESENT |-> NEG_RST && !TRAIN_TX_TICK && !NEG_TICK;
   endproperty
   a_neg_absent: assert property (p_neg_absent) // [R08]
      else $error("negotiation active without the option");

   property p_train_src;
      @(posedge CLK) disable iff (SRST)
      TRAIN_RX_TICK |-> $past(syn_rise[IRS]) && !$past(rst_r[INE]);
   endproperty
   a_train_src: assert property (p_train_src) // [R09]
      else $error("training tick not from recovered clock");

   property p_neg_spacing;
      @(posedge CLK) disable iff (SRST)
      NEG_TICK |-> $past(neg_cnt_r, 2) == NEG_LAST;
   endproperty
   a_neg_spacing: assert property (p_neg_spacing) // [R10]
      else $error("negotiation tick at wrong rate");

endmodule : empcrs_top

`default_nettype wire

// ### empcrs_partner.sv
// empcrs_partner.sv: serdes and core clock pins that face the coordinator.
// assumes: clk is far faster than any pin; a half period of 0 stops a pin.
`timescale 1ns/1ns
`default_nettype none

module empcrs_partner (
   input wire logic clk,
   input wire logic [23:0] halves,
   output logic [2:0] pins
);
   logic [2:0] pins_r;
   logic [7:0] cnt_r [3];

   // ----------------------------------------------------------------
   // pin generators: bit 0 tx serdes, bit 1 recovered, bit 2 rx core
   // ----------------------------------------------------------------
   initial begin
      pins_r = 3'h0;
      for (int k = 0; k < 3; k++) cnt_r[k] = 8'h00;
   end

   // a stopped pin holds its level, it never free-runs
   // tx rate is the integrator's choice, core rate set by halves, slower than tx in t_rate
   // stream data is outside this model; the user side is taken to answer
   // tx ready in the very tick that allows it
   always @(posedge clk) begin
      for (int k = 0; k < 3; k++) begin
         if (halves[8*k +: 8] != 8'h00) begin
            if (cnt_r[k] + 8'h01 >= halves[8*k +: 8]) begin
               cnt_r[k] <= 8'h00;
               pins_r[k] <= ~pins_r[k];
            end else begin
               cnt_r[k] <= cnt_r[k] + 8'h01;
            end
         end
      end
   end

   assign pins = pins_r;

endmodule : empcrs_partner

`default_nettype wire

// ### eth_mac_pcs_clock_reset_scheme_test.sv
// eth_mac_pcs_clock_reset_scheme_test.sv: self-checking bench of empcrs_top.
// assumes: empcrs_pkg and empcrs_partner are compiled first.
`timescale 1ns/1ns
`default_nettype none

module eth_mac_pcs_clock_reset_scheme_test import empcrs_pkg::*;;
   logic clk, srst, mode_in, tx_rq, rx_rq, core_rq, neg_rq, hlp_rq;
   logic [23:0] halves;
   wire logic [2:0] pins;
   logic tx_tk, rx_tk, st_tk, ttx_tk, trx_tk, neg_tk, ms_tk, hlp_tk;
   logic tx_rst, rxs_rst, rxc_rst, neg_rst, hlp_rst, mode_q, slow;
   logic [1:0] doms;
   wire logic [12:0] sig;
   logic nx_rst, nx_tk, nx_ttx, nx_trx, nx_ms;
   int failures, n_compared;

   assign sig = {slow, hlp_rst, neg_rst, rxc_rst, rxs_rst, tx_rst,
      hlp_tk, neg_tk, trx_tk, ttx_tk, st_tk, rx_tk, tx_tk};

   empcrs_partner far_side (.clk(clk), .halves(halves), .pins(pins));

   empcrs_top uut (.CLK(clk), .SRST(srst), .TX_SERDES_CLK_IN(pins[0]),
      .RX_SERDES_CLK_IN(pins[1]), .RX_CORE_CLK_IN(pins[2]),
      .FIFO_MODE_IN(mode_in), .TX_RESET_IN(tx_rq), .RX_RESET_IN(rx_rq),
      .RX_CORE_RESET_IN(core_rq), .NEG_RESET_IN(neg_rq),
      .HELPER_RESET_IN(hlp_rq), .TX_CLK_TICK(tx_tk), .RX_CLK_TICK(rx_tk),
      .RX_STREAM_TICK(st_tk), .TRAIN_TX_TICK(ttx_tk),
      .TRAIN_RX_TICK(trx_tk), .NEG_TICK(neg_tk), .NEG_MS_TICK(ms_tk),
      .HELPER_TICK(hlp_tk), .TX_RST(tx_rst), .RX_SERDES_RST(rxs_rst),
      .RX_CORE_RST(rxc_rst), .NEG_RST(neg_rst), .HELPER_RST(hlp_rst),
      .FIFO_MODE(mode_q), .DOMAIN_COUNT(doms), .RX_CORE_SLOW(slow));

   // same core built without the negotiation option
   empcrs_top #(.AN_PRESENT(1'h0)) no_neg (.CLK(clk), .SRST(srst),
      .TX_SERDES_CLK_IN(pins[0]), .RX_SERDES_CLK_IN(pins[1]),
      .RX_CORE_CLK_IN(pins[2]), .FIFO_MODE_IN(mode_in),
      .TX_RESET_IN(tx_rq), .RX_RESET_IN(rx_rq), .RX_CORE_RESET_IN(core_rq),
      .NEG_RESET_IN(neg_rq), .HELPER_RESET_IN(hlp_rq), .TX_CLK_TICK(),
      .RX_CLK_TICK(), .RX_STREAM_TICK(), .TRAIN_TX_TICK(nx_ttx),
      .TRAIN_RX_TICK(nx_trx), .NEG_TICK(nx_tk), .NEG_MS_TICK(nx_ms),
      .HELPER_TICK(), .TX_RST(), .RX_SERDES_RST(), .RX_CORE_RST(),
      .NEG_RST(nx_rst), .HELPER_RST(), .FIFO_MODE(), .DOMAIN_COUNT(),
      .RX_CORE_SLOW());

   // ----------------------------------------------------------------
   // shared helpers
   // ----------------------------------------------------------------
   initial clk = 1'b0;
   always #25 clk = ~clk;

   task automatic conclude();
      if (failures == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : conclude

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   // inputs move 1 ns after the edge, outputs are read there as well
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task automatic wait_for(input int i, input logic v, input int lim);
      int k;
      k = 0;
      while (sig[i] !== v && k < lim) begin
         tick(1);
         k++;
      end
      check(16'(sig[i]), 16'(v));
   endtask : wait_for

   // cycles between two ticks of one output
   task automatic gap(input int i, input logic [15:0] exp);
      logic [15:0] n;
      wait_for(i, 1'b1, 100);
      tick(1);
      n = 16'h0001;
      while (sig[i] !== 1'b1 && n < 16'h0064) begin
         tick(1);
         n++;
      end
      check(n, exp);
   endtask : gap

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      srst = 1'b1;
      tick(10);
      check(16'(sig[11:7]), 16'h001F);
      check(16'({mode_q, doms, slow}), 16'h000E);
      check(16'(sig[6:0]), 16'h0000);
      srst = 1'b0;
   endtask : t_reset

   task automatic t_release();
      core_rq = 1'b0;
      tick(3);
      neg_rq = 1'b0;
      hlp_rq = 1'b0;
      tick(5);
      rx_rq = 1'b0;
      tick(2);
      tx_rq = 1'b0;
      wait_for(9, 1'b0, 200);
      check(16'(rxs_rst), 16'h0000);
      wait_for(7, 1'b0, 200);
      wait_for(10, 1'b0, 200);
      wait_for(11, 1'b0, 200);
   endtask : t_release

   task automatic t_tx_walk();
      halves[7:0] = 8'h00;
      tx_rq = 1'b1;
      tick(3);
      check(16'(tx_rst), 16'h0001);
      check(16'(rxs_rst), 16'h0000);
      tx_rq = 1'b0;
      tick(60);
      check(16'(tx_rst), 16'h0001);
      halves[7:0] = 8'h04;
      tick(20);
      check(16'(tx_rst), 16'h0001);
      wait_for(7, 1'b0, 60);
   endtask : t_tx_walk

   task automatic t_ticks();
      logic [15:0] exp [7];
      exp = '{16'h0008, 16'h000A, 16'h0006, 16'h0008, 16'h000A,
         16'h0004, 16'h0002};
      halves = 24'h030504;
      tick(30);
      for (int i = 0; i < 7; i++) gap(i, exp[i]);
   endtask : t_ticks

   task automatic t_rate();
      halves = 24'h060404;
      wait_for(12, 1'b1, 600);
      halves = 24'h040404;
      core_rq = 1'b1;
      wait_for(9, 1'b1, 10);
      core_rq = 1'b0;
      wait_for(9, 1'b0, 100);
      check(16'(slow), 16'h0000);
      tick(400);
      check(16'(slow), 16'h0000);
   endtask : t_rate

   task automatic t_lowlat();
      tx_rq = 1'b1;
      rx_rq = 1'b1;
      wait_for(7, 1'b1, 10);
      wait_for(8, 1'b1, 10);
      mode_in = 1'b0;
      tick(4);
      tx_rq = 1'b0;
      rx_rq = 1'b0;
      wait_for(7, 1'b0, 100);
      wait_for(8, 1'b0, 100);
      check(16'({mode_q, doms}), 16'h0002);
      check(16'(rxc_rst), 16'h0001);
      halves = 24'h030504;
      gap(2, 16'h000A);
      mode_in = 1'b1;
      tick(20);
      check(16'(mode_q), 16'h0000);
      tx_rq = 1'b1;
      rx_rq = 1'b1;
      wait_for(8, 1'b1, 10);
      tick(3);
      check(16'({mode_q, doms}), 16'h0007);
      tx_rq = 1'b0;
      rx_rq = 1'b0;
      wait_for(8, 1'b0, 100);
      wait_for(9, 1'b0, 200);
   endtask : t_lowlat

   task automatic t_neg();
      logic [15:0] n;
      neg_rq = 1'b1;
      wait_for(10, 1'b1, 10);
      n = 16'h0000;
      repeat (40) begin
         tick(1);
         n = n + 16'(ttx_tk) + 16'(trx_tk);
      end
      check(n, 16'h0000);
      neg_rq = 1'b0;
      wait_for(10, 1'b0, 100);
      gap(3, 16'h0008);
      n = 16'h0000;
      repeat (40) begin
         tick(1);
         n = n + 16'(!nx_rst) + 16'(nx_tk) + 16'(nx_ms);
         n = n + 16'(nx_ttx) + 16'(nx_trx);
      end
      check(n, 16'h0000);
   endtask : t_neg

   // millisecond tick spacing: one ms of the 20 MHz clock
   task automatic t_ms();
      logic [15:0] n;
      n = 16'h0000;
      while (ms_tk !== 1'b1 && n < 16'h5DC0) begin
         tick(1);
         n++;
      end
      tick(1);
      n = 16'h0001;
      while (ms_tk !== 1'b1 && n < 16'h5DC0) begin
         tick(1);
         n++;
      end
      check(n, 16'h4E20);
   endtask : t_ms

   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      failures = 0;
      n_compared = 0;
      srst = 1'b1;
      mode_in = 1'b1;
      {tx_rq, rx_rq, core_rq, neg_rq, hlp_rq} = 5'h1F;
      halves = 24'h040404;
      t_reset();
      t_release();
      t_tx_walk();
      t_ticks();
      t_rate();
      t_lowlat();
      t_neg();
      t_ms();
      conclude();
   end

   // two millisecond ticks dominate, about 41000 cycles; allow 80000
   initial begin
      #(50 * 80000);
      failures++;
      conclude();
   end

endmodule : eth_mac_pcs_clock_reset_scheme_test

`default_nettype wire
